//--- lsgd_map.vh
`ifndef LSGD_MAP_VH
`define LSGD_MAP_VH

`define LSGD_ADDR_W        3
`define LSGD_OFF_PIN_DATA  3'h0
`define LSGD_OFF_LATCH     3'h1
`define LSGD_OFF_DIR       3'h2
`define LSGD_OFF_PORT_G_DATA_AND_PULLUPS     3'h3
`define LSGD_OFF_SEGEN     3'h4
`define LSGD_OFF_CTRL      3'h5

`define LSGD_PULLUP_BIT    7
`define LSGD_CTRL_PLS_BIT  0

`define LSGD_RST_LATCH     8'h00
`define LSGD_RST_DIR       8'hff
`define LSGD_RST_PORT_G_DATA_AND_PULLUPS     8'h00
`define LSGD_RST_SEGEN     8'h00
`define LSGD_RST_CTRL      8'h00

`endif

//--- lsgd_pin.v
`timescale 1ns/1ps
module lsgd_pin (
  input  wire ref_clk,
  input  wire srst,
  input  wire dir_in,
  input  wire latch_val,
  input  wire seg_en,
  input  wire seg_val,
  input  wire pls_sel,
  input  wire pls_val,
  input  wire pu_en,
  output reg  pin_o_r,
  output reg  pin_oe_r,
  output reg  seg_drive_r,
  output reg  pullup_r
);

  reg pin_o_nxt;
  reg pin_oe_nxt;

  // Segment drive owns the pin first, then the pulse output, then the port.
  always @* begin
    pin_o_nxt  = 1'b0;
    pin_oe_nxt = 1'b0;
    if (seg_en) begin
      pin_o_nxt  = 1'b0;
      pin_oe_nxt = 1'b0;
    end else if (pls_sel) begin
      pin_o_nxt  = pls_val;
      pin_oe_nxt = 1'b1;
    end else if (!dir_in) begin
      pin_o_nxt  = latch_val;
      pin_oe_nxt = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      pin_o_r     <= 1'b0;
      pin_oe_r    <= 1'b0;
      seg_drive_r <= 1'b0;
      pullup_r    <= 1'b0;
    end else begin
      pin_o_r     <= pin_o_nxt;
      pin_oe_r    <= pin_oe_nxt;
      seg_drive_r <= seg_en ? seg_val : 1'b0;
      pullup_r    <= pu_en & ~pin_oe_nxt & ~seg_en;
    end
  end

endmodule

//--- lsgd_port.v
// How it works
// - Eight pins each have a direction bit: 0 drives the pin from its latch, 1 makes it an input.
// - Reading pin data returns the pin levels; an output pin is driven from its latch bit.
// - Reset sets every direction bit so that all pins are inputs.
// - Bit 7 of the port G register enables the weak pull-ups of all eight pins.
// - A pin's pull-up is off while that pin is an output.
// - Reset clears the pull-up enable bit so all pull-ups start off.
// - A set segment enable bit hands its pin to the segment drive, ignoring direction.
// - Port input and output on a pin work only while its segment enable bit is clear.
// - Pin 0 can carry the charge pulse output, which overrides its direction bit.
// - Writing pin data or the latch register updates the output latches.
`timescale 1ns/1ps
`include "lsgd_map.vh"
module lsgd_port (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_r,
  input  wire [7:0] pin_i,
  output wire [7:0] pin_o,
  output wire [7:0] pin_oe,
  output wire [7:0] pin_pullup,
  output wire [7:0] seg_drive,
  input  wire [7:0] segment_drive_output,
  input  wire       charge_pulse_output,
  input  wire [4:0] port_g_pins_in
);

  reg  [7:0] latch_r;
  reg  [7:0] dir_r;
  reg  [7:0] port_g_data_and_pullups_r;
  reg  [7:0] segen_r;
  reg  [7:0] ctrl_r;
  reg  [7:0] rdata_nxt;
  wire       pu_en;
  wire       pls_sel;
  wire [7:0] pin_level;

  assign pu_en   = port_g_data_and_pullups_r[`LSGD_PULLUP_BIT];
  assign pls_sel = ctrl_r[`LSGD_CTRL_PLS_BIT];

  always @(posedge ref_clk) begin
    if (srst) begin
      latch_r <= `LSGD_RST_LATCH;
      dir_r   <= `LSGD_RST_DIR;
      port_g_data_and_pullups_r <= `LSGD_RST_PORT_G_DATA_AND_PULLUPS;
      segen_r <= `LSGD_RST_SEGEN;
      ctrl_r  <= `LSGD_RST_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        `LSGD_OFF_PIN_DATA: latch_r <= reg_wdata;
        `LSGD_OFF_LATCH:    latch_r <= reg_wdata;
        `LSGD_OFF_DIR:      dir_r   <= reg_wdata;
        `LSGD_OFF_PORT_G_DATA_AND_PULLUPS:    port_g_data_and_pullups_r <= {reg_wdata[7:5], 5'h00};
        `LSGD_OFF_SEGEN:    segen_r <= reg_wdata;
        `LSGD_OFF_CTRL:     ctrl_r  <= {7'h00, reg_wdata[0]};
        default: begin
        end
      endcase
    end
  end

  // A pin owned by its segment reads as zero since its digital input is cut off.
  assign pin_level = pin_i & ~segen_r;

  always @* begin
    case (reg_addr)
      `LSGD_OFF_PIN_DATA: rdata_nxt = pin_level;
      `LSGD_OFF_LATCH:    rdata_nxt = latch_r;
      `LSGD_OFF_DIR:      rdata_nxt = dir_r;
      `LSGD_OFF_PORT_G_DATA_AND_PULLUPS:    rdata_nxt = {port_g_data_and_pullups_r[7:5], port_g_pins_in};
      `LSGD_OFF_SEGEN:    rdata_nxt = segen_r;
      `LSGD_OFF_CTRL:     rdata_nxt = ctrl_r;
      default:            rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      lsgd_pin u_pin (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .dir_in      (dir_r[gi]),
        .latch_val   (latch_r[gi]),
        .seg_en      (segen_r[gi]),
        .seg_val     (segment_drive_output[gi]),
        .pls_sel     ((gi == 0) ? pls_sel : 1'b0),
        .pls_val     (charge_pulse_output),
        .pu_en       (pu_en),
        .pin_o_r     (pin_o[gi]),
        .pin_oe_r    (pin_oe[gi]),
        .seg_drive_r (seg_drive[gi]),
        .pullup_r    (pin_pullup[gi])
      );
    end
  endgenerate

endmodule

//--- lsgd_port_assertions.sv
`timescale 1ns/1ps
module lsgd_chk (
  input logic       ref_clk, srst, reg_wr, reg_rd,
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata, reg_rdata_r, pin_oe, pin_pullup, seg_drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_wr_rd(w, r);
    reg_wr && reg_addr == w ##1 reg_rd && reg_addr == r;
  endsequence
  a_pull_out: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pullup on output");
  a_seg_owns: assert property ((seg_drive & (pin_oe | pin_pullup)) == 8'h00)
    else $error("segment pin shared");
  a_reset_quiet: assert property ($fell(srst) |-> (pin_oe | pin_pullup) == 8'h00)
    else $error("reset state");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata_r == 8'h00)
    else $error("stray rdata");
  a_dir_back: assert property (s_wr_rd(3'h2, 3'h2) |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("dir readback");
  a_latch_back: assert property (s_wr_rd(3'h0, 3'h1) |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("latch readback");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata_r == 8'h00)
    else $error("unmapped read");
  a_oe_write: assert property ($changed(pin_oe) |-> $past(reg_wr, 2))
    else $error("oe without write");
endmodule
bind lsgd_port lsgd_chk lsgd_chk_inst (.*);

//--- lsgd_port_test.sv
`timescale 1ns/1ps
module lsgd_port_test;
  logic       ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, charge_pulse_output = 1;
  logic [2:0] reg_addr = 3'h0;
  logic [4:0] port_g_pins_in = 5'h0a;
  logic [7:0] reg_wdata = 8'h00, pin_i = 8'hfc, segment_drive_output = 8'hff;
  logic [7:0] reg_rdata_r, pin_o, pin_oe, pin_pullup, seg_drive;
  int         error_cnt = 0, cmp_count = 0;
  lsgd_port lsgd_port_inst (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  task chk(input logic [7:0] s, e, input string n);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // Accesses start just after a rising edge and end just after one.
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_r, e, "rdata");
    @(posedge ref_clk);
  endtask
  task idle;
    @(posedge ref_clk);
    #1;
  endtask
  task results;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000;
    error_cnt++;
    results;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    rd(3'h2, 8'hff);
    rd(3'h3, 8'h0a);
    wr(3'h3, 8'h80);
    idle;
    chk(pin_pullup, 8'hff, "pullup");
    @(posedge ref_clk);
    wr(3'h0, 8'ha5);
    rd(3'h1, 8'ha5);
    wr(3'h2, 8'h0f);
    rd(3'h2, 8'h0f);
    idle;
    chk(pin_oe, 8'hf0, "oe");
    chk(pin_o & 8'hf0, 8'ha0, "pin_o");
    chk(pin_pullup, 8'h0f, "pullup");
    @(posedge ref_clk);
    rd(3'h0, 8'hfc);
    wr(3'h4, 8'hc0);
    idle;
    chk(seg_drive, 8'hc0, "seg");
    chk(pin_oe, 8'h30, "oe");
    @(posedge ref_clk);
    rd(3'h0, 8'h3c);
    wr(3'h5, 8'h01);
    idle;
    chk({6'h00, pin_oe[0], pin_o[0]}, 8'h03, "pulse");
    @(posedge ref_clk);
    charge_pulse_output <= 1'b0;
    idle;
    chk({6'h00, pin_oe[0], pin_o[0]}, 8'h02, "pulse");
    @(posedge ref_clk);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'h00);
    rd(3'h7, 8'h00);
    results;
  end
endmodule
